/* File: logic/iftc_pkg.sv */
// shared constants and types for the instruction timing and flag core
`default_nettype none
package iftc_pkg;
    localparam int CLKS_PER_MC = 4;
    localparam logic [1:0] PH_FIRST = 2'h0;
    localparam logic [1:0] PH_LAST = 2'h3;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_LJMP = 8'h02;
    localparam logic [7:0] OP_LCALL = 8'h12;
    localparam logic [7:0] OP_RRC = 8'h13;
    localparam logic [7:0] OP_RLC = 8'h33;
    localparam logic [7:0] OP_ORL_C = 8'h72;
    localparam logic [7:0] OP_SJMP = 8'h80;
    localparam logic [7:0] OP_ANL_C = 8'h82;
    localparam logic [7:0] OP_DIV = 8'h84;
    localparam logic [7:0] OP_ORL_CN = 8'hA0;
    localparam logic [7:0] OP_MOV_CB = 8'hA2;
    localparam logic [7:0] OP_MUL = 8'hA4;
    localparam logic [7:0] OP_ANL_CN = 8'hB0;
    localparam logic [7:0] OP_COMPLEMENT_CARRY_BIT = 8'hB3;
    localparam logic [7:0] OP_CLEAR_CARRY_BIT = 8'hC3;
    localparam logic [7:0] OP_SET_C = 8'hD3;
    localparam logic [7:0] OP_DA = 8'hD4;

    localparam logic [3:0] HI_ADD = 4'h2;
    localparam logic [3:0] HI_ADD_WITH_CARRY = 4'h3;
    localparam logic [3:0] HI_SUBTRACT_WITH_BORROW = 4'h9;
    localparam logic [3:0] HI_COMPARE_JUMP_NOT_EQUAL = 4'hB;
    localparam logic [3:0] LO_IMM = 4'h4;
    localparam logic [3:0] LO_DIR = 4'h5;
    localparam logic [3:0] LO_IND0 = 4'h6;
    localparam logic [3:0] LO_IND1 = 4'h7;
    localparam logic [3:0] LO_REG0 = 4'h8;
    localparam logic [3:0] LO_ABS = 4'h1;

    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [8:0] DA_LO_ADJ = 9'h006;
    localparam logic [8:0] DA_HI_ADJ = 9'h060;

    typedef enum logic [4:0] {
        OPK_NOP, OPK_ADD, OPK_ADD_WITH_CARRY, OPK_SUBTRACT_WITH_BORROW, OPK_MUL, OPK_DIV, OPK_DA,
        OPK_RRC, OPK_RLC, OPK_SET_C, OPK_CLEAR_CARRY_BIT, OPK_COMPLEMENT_CARRY_BIT, OPK_ANL_C,
        OPK_ANL_CN, OPK_ORL_C, OPK_ORL_CN, OPK_MOV_CB, OPK_COMPARE_JUMP_NOT_EQUAL,
        OPK_ABS_JMP, OPK_LONG_JMP, OPK_SHORT_JMP
    } iftc_op_t;

    typedef enum logic [2:0] {
        SRC_NONE, SRC_REG, SRC_IND, SRC_DIR, SRC_IMM
    } iftc_src_t;

    typedef enum logic {
        ST_OPCODE, ST_BODY
    } iftc_state_t;
endpackage
`default_nettype wire

/* File: logic/iftc_decode.sv */
// opcode decoder: operation class, operand source, length and cycle count
`default_nettype none
module iftc_decode (
    // opcode in
    input wire logic [7:0] opcode,
    // decoded fields
    output iftc_pkg::iftc_op_t op_kind,
    output iftc_pkg::iftc_src_t src_kind,
    output logic [1:0] n_bytes,
    output logic [2:0] n_cycles
);
    logic [3:0] hi;
    logic [3:0] lo;
    logic is_jump;

    assign hi = opcode[7:4];
    assign lo = opcode[3:0];

    always_comb
    begin
        op_kind = iftc_pkg::OPK_NOP;
        src_kind = iftc_pkg::SRC_NONE;
        n_bytes = 2'h1;
        is_jump = 1'b0;
        if ((hi == iftc_pkg::HI_ADD || hi == iftc_pkg::HI_ADD_WITH_CARRY ||
             hi == iftc_pkg::HI_SUBTRACT_WITH_BORROW || hi == iftc_pkg::HI_COMPARE_JUMP_NOT_EQUAL) &&
            lo >= iftc_pkg::LO_IMM)
        begin
            case (hi)
                iftc_pkg::HI_ADD: op_kind = iftc_pkg::OPK_ADD;
                iftc_pkg::HI_ADD_WITH_CARRY: op_kind = iftc_pkg::OPK_ADD_WITH_CARRY;
                iftc_pkg::HI_SUBTRACT_WITH_BORROW: op_kind = iftc_pkg::OPK_SUBTRACT_WITH_BORROW;
                default: op_kind = iftc_pkg::OPK_COMPARE_JUMP_NOT_EQUAL;
            endcase
            if (lo == iftc_pkg::LO_IMM)
                src_kind = iftc_pkg::SRC_IMM;
            else if (lo == iftc_pkg::LO_DIR)
                src_kind = iftc_pkg::SRC_DIR;
            else if (lo == iftc_pkg::LO_IND0 || lo == iftc_pkg::LO_IND1)
                src_kind = iftc_pkg::SRC_IND;
            else
                src_kind = iftc_pkg::SRC_REG;
            n_bytes = (src_kind == iftc_pkg::SRC_IMM ||
                       src_kind == iftc_pkg::SRC_DIR) ? 2'h2 : 2'h1;
            if (hi == iftc_pkg::HI_COMPARE_JUMP_NOT_EQUAL)
            begin
                n_bytes = 2'h3;
                is_jump = 1'b1;
            end
        end
        else if (lo == iftc_pkg::LO_ABS)
        begin
            op_kind = iftc_pkg::OPK_ABS_JMP;
            n_bytes = 2'h2;
            is_jump = 1'b1;
        end
        else
        begin
            case (opcode)
                iftc_pkg::OP_LJMP, iftc_pkg::OP_LCALL:
                begin
                    op_kind = iftc_pkg::OPK_LONG_JMP;
                    n_bytes = 2'h3;
                    is_jump = 1'b1;
                end
                iftc_pkg::OP_SJMP:
                begin
                    op_kind = iftc_pkg::OPK_SHORT_JMP;
                    n_bytes = 2'h2;
                    is_jump = 1'b1;
                end
                iftc_pkg::OP_MUL: op_kind = iftc_pkg::OPK_MUL;
                iftc_pkg::OP_DIV: op_kind = iftc_pkg::OPK_DIV;
                iftc_pkg::OP_DA: op_kind = iftc_pkg::OPK_DA;
                iftc_pkg::OP_RRC: op_kind = iftc_pkg::OPK_RRC;
                iftc_pkg::OP_RLC: op_kind = iftc_pkg::OPK_RLC;
                iftc_pkg::OP_SET_C: op_kind = iftc_pkg::OPK_SET_C;
                iftc_pkg::OP_CLEAR_CARRY_BIT: op_kind = iftc_pkg::OPK_CLEAR_CARRY_BIT;
                iftc_pkg::OP_COMPLEMENT_CARRY_BIT: op_kind = iftc_pkg::OPK_COMPLEMENT_CARRY_BIT;
                iftc_pkg::OP_ANL_C, iftc_pkg::OP_ANL_CN, iftc_pkg::OP_ORL_C,
                iftc_pkg::OP_ORL_CN, iftc_pkg::OP_MOV_CB:
                begin
                    n_bytes = 2'h2;
                    src_kind = iftc_pkg::SRC_DIR;
                    case (opcode)
                        iftc_pkg::OP_ANL_C: op_kind = iftc_pkg::OPK_ANL_C;
                        iftc_pkg::OP_ANL_CN: op_kind = iftc_pkg::OPK_ANL_CN;
                        iftc_pkg::OP_ORL_C: op_kind = iftc_pkg::OPK_ORL_C;
                        iftc_pkg::OP_ORL_CN: op_kind = iftc_pkg::OPK_ORL_CN;
                        default: op_kind = iftc_pkg::OPK_MOV_CB;
                    endcase
                end
                default: op_kind = iftc_pkg::OPK_NOP;
            endcase
        end
    end

    assign n_cycles = {1'b0, n_bytes} + {2'h0, is_jump};
endmodule
`default_nettype wire

/* File: logic/iftc_core.sv */
// instruction sequencer with machine-cycle timing and flag update
`default_nettype none
module iftc_core (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // program memory
    output logic code_rd,
    output logic [15:0] code_addr,
    input wire logic [7:0] code_data,
    // operand access, answered in the same clock
    output iftc_pkg::iftc_src_t operand_kind,
    output logic [7:0] operand_ref,
    input wire logic [7:0] operand_data,
    input wire logic bit_value,
    // status
    output logic mc_start,
    output logic insn_done,
    output logic [7:0] acc_q,
    output logic [7:0] b_q,
    output logic cy_q,
    output logic ov_q,
    output logic ac_q
);
    iftc_pkg::iftc_state_t st_q, st_d;
    logic [1:0] phase_q, phase_d;
    logic [15:0] pc_q, pc_d;
    logic [7:0] opcode_q, opcode_d, byte2_q, byte2_d, byte3_q, byte3_d;
    logic [2:0] cyc_left_q, cyc_left_d;
    logic [1:0] bytes_left_q, bytes_left_d, got_q, got_d;
    logic [7:0] acc_d, b_d;
    logic cy_d, ov_d, ac_d;

    logic [7:0] cur_op, b2, b3, lhs, rhs, sub_rhs;
    iftc_pkg::iftc_op_t kind;
    iftc_pkg::iftc_src_t src;
    logic [1:0] n_bytes;
    logic [2:0] n_cycles;
    logic fetching, last_cycle, cin;
    logic [15:0] pc_after, product;
    logic [8:0] sum9, da9;
    logic [4:0] sum5;
    logic [7:0] sum7;

    assign cur_op = (st_q == iftc_pkg::ST_OPCODE) ? code_data : opcode_q;

    iftc_decode u_decode (
        .opcode(cur_op),
        .op_kind(kind),
        .src_kind(src),
        .n_bytes(n_bytes),
        .n_cycles(n_cycles)
    );

    assign fetching = (st_q == iftc_pkg::ST_OPCODE) ||
                      (bytes_left_q != 2'h0);
    assign code_rd = fetching && (phase_q == iftc_pkg::PH_FIRST);
    assign code_addr = pc_q;
    assign mc_start = (phase_q == iftc_pkg::PH_FIRST);
    assign last_cycle = (st_q == iftc_pkg::ST_OPCODE) ?
                        (n_cycles == 3'h1) : (cyc_left_q == 3'h1);
    assign insn_done = last_cycle && (phase_q == iftc_pkg::PH_LAST);
    assign pc_after = fetching ? pc_q + 16'h0001 : pc_q;

    // operand bytes arriving in the current cycle are used directly
    assign b2 = (st_q == iftc_pkg::ST_BODY && got_q == 2'h0) ?
                code_data : byte2_q;
    assign b3 = (st_q == iftc_pkg::ST_BODY && got_q == 2'h1) ?
                code_data : byte3_q;

    assign operand_kind = src;
    // indirect forms name pointer register 0 or 1 by the low opcode bit
    assign operand_ref = (src == iftc_pkg::SRC_DIR) ? b2 :
                         (src == iftc_pkg::SRC_IND) ? {7'h00, cur_op[0]} :
                         {5'h00, cur_op[2:0]};

    assign cin = (kind == iftc_pkg::OPK_ADD) ? 1'b0 : cy_q;
    // compare-jump on a register or indirect cell takes the immediate byte
    assign rhs = (src == iftc_pkg::SRC_IMM ||
                  (kind == iftc_pkg::OPK_COMPARE_JUMP_NOT_EQUAL && src != iftc_pkg::SRC_DIR)) ?
                 b2 : operand_data;
    assign sub_rhs = (kind == iftc_pkg::OPK_SUBTRACT_WITH_BORROW) ? ~rhs : rhs;
    assign lhs = (kind == iftc_pkg::OPK_COMPARE_JUMP_NOT_EQUAL && src != iftc_pkg::SRC_IMM &&
                  src != iftc_pkg::SRC_DIR) ? operand_data : acc_q;

    always_comb
    begin
        // subtract as add of complement with inverted carry in
        sum5 = {1'b0, acc_q[3:0]} + {1'b0, sub_rhs[3:0]} +
               {4'h0, (kind == iftc_pkg::OPK_SUBTRACT_WITH_BORROW) ? ~cin : cin};
        sum7 = {1'b0, acc_q[6:0]} + {1'b0, sub_rhs[6:0]} +
               {7'h00, (kind == iftc_pkg::OPK_SUBTRACT_WITH_BORROW) ? ~cin : cin};
        sum9 = {1'b0, acc_q} + {1'b0, sub_rhs} +
               {8'h00, (kind == iftc_pkg::OPK_SUBTRACT_WITH_BORROW) ? ~cin : cin};
        product = {8'h00, acc_q} * {8'h00, b_q};
        da9 = {1'b0, acc_q};
        if (acc_q[3:0] > iftc_pkg::BCD_MAX || ac_q)
            da9 = da9 + iftc_pkg::DA_LO_ADJ;
        if (da9[7:4] > iftc_pkg::BCD_MAX || cy_q || da9[8])
            da9 = da9 + iftc_pkg::DA_HI_ADJ;
    end

    always_comb
    begin
        st_d = st_q;
        phase_d = phase_q + 2'h1;
        pc_d = pc_q;
        opcode_d = opcode_q;
        byte2_d = byte2_q;
        byte3_d = byte3_q;
        cyc_left_d = cyc_left_q;
        bytes_left_d = bytes_left_q;
        got_d = got_q;
        acc_d = acc_q;
        b_d = b_q;
        cy_d = cy_q;
        ov_d = ov_q;
        ac_d = ac_q;
        if (phase_q == iftc_pkg::PH_LAST)
        begin
            pc_d = pc_after;
            if (st_q == iftc_pkg::ST_OPCODE)
            begin
                opcode_d = code_data;
                cyc_left_d = n_cycles - 3'h1;
                bytes_left_d = n_bytes - 2'h1;
                got_d = 2'h0;
                if (n_cycles != 3'h1)
                    st_d = iftc_pkg::ST_BODY;
            end
            else
            begin
                cyc_left_d = cyc_left_q - 3'h1;
                if (fetching)
                begin
                    bytes_left_d = bytes_left_q - 2'h1;
                    got_d = got_q + 2'h1;
                    if (got_q == 2'h0)
                        byte2_d = code_data;
                    else
                        byte3_d = code_data;
                end
                if (last_cycle)
                    st_d = iftc_pkg::ST_OPCODE;
            end
            if (last_cycle)
            begin
                case (kind)
                    iftc_pkg::OPK_ADD, iftc_pkg::OPK_ADD_WITH_CARRY,
                    iftc_pkg::OPK_SUBTRACT_WITH_BORROW:
                    begin
                        acc_d = sum9[7:0];
                        cy_d = (kind == iftc_pkg::OPK_SUBTRACT_WITH_BORROW) ? ~sum9[8] :
                               sum9[8];
                        ac_d = (kind == iftc_pkg::OPK_SUBTRACT_WITH_BORROW) ? ~sum5[4] :
                               sum5[4];
                        ov_d = sum9[8] ^ sum7[7];
                    end
                    iftc_pkg::OPK_MUL:
                    begin
                        acc_d = product[7:0];
                        b_d = product[15:8];
                        cy_d = 1'b0;
                        ov_d = (product[15:8] != 8'h00);
                    end
                    iftc_pkg::OPK_DIV:
                    begin
                        cy_d = 1'b0;
                        ov_d = (b_q == 8'h00);
                        if (b_q != 8'h00)
                        begin
                            acc_d = acc_q / b_q;
                            b_d = acc_q % b_q;
                        end
                    end
                    iftc_pkg::OPK_DA:
                    begin
                        acc_d = da9[7:0];
                        cy_d = cy_q | da9[8];
                    end
                    iftc_pkg::OPK_RRC:
                    begin
                        acc_d = {cy_q, acc_q[7:1]};
                        cy_d = acc_q[0];
                    end
                    iftc_pkg::OPK_RLC:
                    begin
                        acc_d = {acc_q[6:0], cy_q};
                        cy_d = acc_q[7];
                    end
                    iftc_pkg::OPK_SET_C: cy_d = 1'b1;
                    iftc_pkg::OPK_CLEAR_CARRY_BIT: cy_d = 1'b0;
                    iftc_pkg::OPK_COMPLEMENT_CARRY_BIT: cy_d = ~cy_q;
                    iftc_pkg::OPK_ANL_C: cy_d = cy_q & bit_value;
                    iftc_pkg::OPK_ANL_CN: cy_d = cy_q & ~bit_value;
                    iftc_pkg::OPK_ORL_C: cy_d = cy_q | bit_value;
                    iftc_pkg::OPK_ORL_CN: cy_d = cy_q | ~bit_value;
                    iftc_pkg::OPK_MOV_CB: cy_d = bit_value;
                    iftc_pkg::OPK_COMPARE_JUMP_NOT_EQUAL:
                    begin
                        cy_d = (lhs < rhs);
                        if (lhs != rhs)
                            pc_d = pc_after + {{8{b3[7]}}, b3};
                    end
                    iftc_pkg::OPK_ABS_JMP:
                        pc_d = {pc_after[15:11], opcode_q[7:5], b2};
                    iftc_pkg::OPK_LONG_JMP: pc_d = {b2, b3};
                    iftc_pkg::OPK_SHORT_JMP:
                        pc_d = pc_after + {{8{b2[7]}}, b2};
                    default: acc_d = acc_q;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= iftc_pkg::ST_OPCODE;
            phase_q <= iftc_pkg::PH_FIRST;
            pc_q <= iftc_pkg::PC_RESET;
            opcode_q <= iftc_pkg::OP_NOP;
            byte2_q <= iftc_pkg::BYTE_RESET;
            byte3_q <= iftc_pkg::BYTE_RESET;
            cyc_left_q <= 3'h0;
            bytes_left_q <= 2'h0;
            got_q <= 2'h0;
            acc_q <= iftc_pkg::BYTE_RESET;
            b_q <= iftc_pkg::BYTE_RESET;
            cy_q <= 1'b0;
            ov_q <= 1'b0;
            ac_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            phase_q <= phase_d;
            pc_q <= pc_d;
            opcode_q <= opcode_d;
            byte2_q <= byte2_d;
            byte3_q <= byte3_d;
            cyc_left_q <= cyc_left_d;
            bytes_left_q <= bytes_left_d;
            got_q <= got_d;
            acc_q <= acc_d;
            b_q <= b_d;
            cy_q <= cy_d;
            ov_q <= ov_d;
            ac_q <= ac_d;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/iftc_core_assertions.sv */
// assertion checker for the instruction timing and flag core
`default_nettype none
module iftc_core_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // fetch side
    input wire logic code_rd,
    input wire logic [15:0] code_addr,
    input wire logic [7:0] code_data,
    // status
    input wire logic mc_start,
    input wire logic insn_done,
    input wire logic cy_q
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // opcode byte seen at phase 3 of the cycle after a completion
    sequence s_op;
        insn_done ##1 code_rd ##3 1'b1;
    endsequence
    // completion of a one-cycle instruction, opcode still on code_data
    sequence s_one;
        insn_done ##0 $past(insn_done, 4);
    endsequence

    property p_mc_period;
        mc_start |=> !mc_start [*3] ##1 mc_start;
    endproperty
    a_mc_period: assert property (p_mc_period)
        else $error("machine cycle is not four clocks");
    property p_fetch_phase;
        code_rd |-> mc_start;
    endproperty
    a_fetch_phase: assert property (p_fetch_phase)
        else $error("fetch outside phase 0");
    property p_addr_stable;
        !mc_start |-> $stable(code_addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("fetch address moved inside a cycle");
    property p_done_phase;
        insn_done |-> $past(mc_start, 3);
    endproperty
    a_done_phase: assert property (p_done_phase)
        else $error("completion not at phase 3");
    property p_next_fetch;
        insn_done |=> code_rd && mc_start;
    endproperty
    a_next_fetch: assert property (p_next_fetch)
        else $error("next opcode fetch late");
    property p_one_cycle;
        s_op ##0 (code_data[7:3] == 5'h05 || code_data[7:3] == 5'h07
            || code_data == iftc_pkg::OP_NOP) |-> insn_done;
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("one-byte operation not done in one cycle");
    property p_two_cycle;
        s_op ##0 (code_data == 8'h24 || code_data == 8'h25)
            |-> !insn_done ##1 code_rd ##3 insn_done;
    endproperty
    a_two_cycle: assert property (p_two_cycle)
        else $error("two-byte add not done in two cycles");
    property p_short_jump;
        s_op ##0 (code_data == iftc_pkg::OP_SJMP)
            |-> ##4 !insn_done ##4 insn_done;
    endproperty
    a_short_jump: assert property (p_short_jump)
        else $error("short jump not three cycles");
    property p_long_jump;
        s_op ##0 (code_data == iftc_pkg::OP_LJMP)
            |-> ##4 !insn_done ##4 !insn_done ##4 insn_done;
    endproperty
    a_long_jump: assert property (p_long_jump)
        else $error("long jump not four cycles");
    property p_set_carry;
        s_one ##0 (code_data == iftc_pkg::OP_SET_C) |=> cy_q;
    endproperty
    a_set_carry: assert property (p_set_carry)
        else $error("carry not set");
    property p_clr_carry;
        s_one ##0 (code_data == iftc_pkg::OP_CLEAR_CARRY_BIT) |=> !cy_q;
    endproperty
    a_clr_carry: assert property (p_clr_carry)
        else $error("carry not cleared");
endmodule
bind iftc_core iftc_core_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .code_rd(code_rd), .code_addr(code_addr), .code_data(code_data),
    .mc_start(mc_start), .insn_done(insn_done), .cy_q(cy_q));
`default_nettype wire

/* File: testbench/instruction_timing_flag_core_tb_top.sv */
// self-checking bench for the instruction timing and flag core
`default_nettype none
module instruction_timing_flag_core_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] code_data = 8'h00;
    logic [7:0] operand_data = 8'h00;
    logic bit_value = 1'b0;
    logic code_rd, mc_start, insn_done, cy_q, ov_q, ac_q;
    logic [15:0] code_addr;
    iftc_pkg::iftc_src_t operand_kind;
    logic [7:0] operand_ref, acc_q, b_q;
    logic [7:0] mem [0:65535];
    logic [7:0] m_acc = 8'h00;
    logic m_cy = 1'b0;
    logic m_ov = 1'b0;
    logic m_ac = 1'b0;
    logic [15:0] exp_pc;
    int errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int fch = 0;
    int ld_c, ld_f;

    iftc_core uut (.ref_clk(ref_clk), .rst_n(rst_n), .code_rd(code_rd),
        .code_addr(code_addr), .code_data(code_data),
        .operand_kind(operand_kind), .operand_ref(operand_ref),
        .operand_data(operand_data), .bit_value(bit_value),
        .mc_start(mc_start), .insn_done(insn_done), .acc_q(acc_q),
        .b_q(b_q), .cy_q(cy_q), .ov_q(ov_q), .ac_q(ac_q));

    function automatic logic [7:0] opv(input logic [7:0] r);
        return r * 8'h1F + 8'h63;
    endfunction

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        fch <= fch + int'(code_rd);
    end
    // program store and operand store answer off the sampling edge
    always @(negedge ref_clk)
    begin
        code_data = mem[code_addr];
        #1;
        operand_data = opv(operand_kind == iftc_pkg::SRC_DIR ?
            operand_ref : {5'h00, operand_ref[2:0]});
        bit_value = operand_ref[0];
    end

    task automatic chk(input string what, input logic [15:0] e,
        input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic arith(input logic [7:0] v, input logic c,
        input logic sub);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] l;
        s = sub ? {1'b0, m_acc} - v - c : {1'b0, m_acc} + v + c;
        h = sub ? {1'b0, m_acc[3:0]} - v[3:0] - c : m_acc[3:0] + v[3:0] + c;
        l = sub ? {1'b0, m_acc[6:0]} - v[6:0] - c : m_acc[6:0] + v[6:0] + c;
        m_acc = s[7:0];
        m_cy = s[8];
        m_ac = h[4];
        m_ov = l[7] ^ s[8];
    endtask

    // runs one instruction; clks of 0 skips the clock count
    task automatic ex(input logic [7:0] op, input logic [7:0] a1,
        input logic [7:0] a2, input int nb, input int clks,
        input logic [15:0] jmp);
        int n;
        mem[exp_pc] = op;
        mem[exp_pc + 16'h1] = a1;
        mem[exp_pc + 16'h2] = a2;
        exp_pc = (jmp !== 16'h0000) ? jmp : exp_pc + 16'(nb);
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (insn_done !== 1'b1 && n < 40);
        chk("completion", 16'h0001, insn_done);
        if (clks != 0)
            chk("clocks", 16'(clks), 16'(cyc - ld_c));
        chk("fetches", 16'(nb), 16'(fch - ld_f));
        ld_c = cyc;
        ld_f = fch;
        @(negedge ref_clk);
        chk("fetch strobe", 16'h0001, code_rd);
        chk("fetch address", exp_pc, code_addr);
        chk("acc", m_acc, acc_q);
        chk("b", 16'h0000, b_q);
        chk("carry", m_cy, cy_q);
        chk("overflow", m_ov, ov_q);
        chk("aux carry", m_ac, ac_q);
    endtask

    task automatic t_nop;
        ex(8'h00, 8'h00, 8'h00, 1, 4, 16'h0000);
    endtask

    task automatic t_add;
        for (int r = 0; r < 8; r++)
        begin
            arith(opv(8'(r)), 1'b0, 1'b0);
            ex(8'h28 + 8'(r), 8'h00, 8'h00, 1, 4, 16'h0000);
        end
        arith(opv(8'h00), 1'b0, 1'b0);
        ex(8'h26, 8'h00, 8'h00, 1, 4, 16'h0000);
        arith(opv(8'h01), 1'b0, 1'b0);
        ex(8'h27, 8'h00, 8'h00, 1, 4, 16'h0000);
        arith(opv(8'h3C), 1'b0, 1'b0);
        ex(8'h25, 8'h3C, 8'h00, 2, 8, 16'h0000);
        arith(8'hC9, 1'b0, 1'b0);
        ex(8'h24, 8'hC9, 8'h00, 2, 8, 16'h0000);
    endtask

    task automatic t_add_with_carry;
        m_cy = 1'b1;
        ex(8'hD3, 8'h00, 8'h00, 1, 4, 16'h0000);
        for (int r = 0; r < 8; r++)
        begin
            arith(opv(8'(r)), m_cy, 1'b0);
            ex(8'h38 + 8'(r), 8'h00, 8'h00, 1, 4, 16'h0000);
        end
    endtask

    task automatic t_subtract_with_borrow;
        arith(8'h7F, m_cy, 1'b1);
        ex(8'h94, 8'h7F, 8'h00, 2, 8, 16'h0000);
        arith(8'hFF, m_cy, 1'b1);
        ex(8'h94, 8'hFF, 8'h00, 2, 8, 16'h0000);
    endtask

    task automatic t_carry;
        m_cy = 1'b1;
        ex(8'hD3, 8'h00, 8'h00, 1, 4, 16'h0000);
        m_cy = 1'b0;
        ex(8'hB3, 8'h00, 8'h00, 1, 4, 16'h0000);
        m_cy = 1'b1;
        ex(8'hB3, 8'h00, 8'h00, 1, 4, 16'h0000);
        m_cy = 1'b0;
        ex(8'hC3, 8'h00, 8'h00, 1, 4, 16'h0000);
    endtask

    task automatic t_muldiv;
        m_cy = 1'b1;
        ex(8'hD3, 8'h00, 8'h00, 1, 4, 16'h0000);
        m_cy = 1'b0;
        m_ov = 1'b1;
        ex(8'h84, 8'h00, 8'h00, 1, 0, 16'h0000);
        m_acc = 8'h00;
        m_ov = 1'b0;
        ex(8'hA4, 8'h00, 8'h00, 1, 0, 16'h0000);
    endtask

    task automatic t_jump;
        ex(8'hB4, 8'h00, 8'h00, 3, 16, 16'h0000);
        ex(8'h80, 8'h02, 8'h00, 2, 12, exp_pc + 16'h4);
        ex(8'h02, 8'h01, 8'h00, 3, 16, 16'h0100);
        ex(8'h00, 8'h00, 8'h00, 1, 4, 16'h0000);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial
    begin
        foreach (mem[i])
            mem[i] = 8'h00;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        do @(negedge ref_clk); while (insn_done !== 1'b1);
        ld_c = cyc;
        ld_f = fch;
        exp_pc = 16'h0001;
        @(negedge ref_clk);
        t_nop;
        t_add;
        t_add_with_carry;
        t_subtract_with_borrow;
        t_carry;
        t_muldiv;
        t_jump;
        wrap_up;
    end

    initial
    begin
        repeat (3000) @(posedge ref_clk);
        errors++;
        wrap_up;
    end
endmodule
`default_nettype wire
